// file: tb/midi_host.sv
// host-side partner: sends midi bytes and consumes transmitted ones
`timescale 1ns/1ns
`default_nettype none
module midi_host (
  input wire logic clk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic tx_ready
);
  // a slow host stalls about one byte in four
  initial tx_ready = 1'b0;
  always @(posedge clk) begin
    tx_ready <= ($urandom % 4) != 0;
  end
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end
  // one pulse per byte; a released line shows the inverse of its value
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the preset manager
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t: %0h vs %0h", $time, a, b); end end
module tb_top;
  import preset_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rx_valid, tx_valid, tx_ready, prompt, mute, block;
  logic [7:0] rx_data, tx_data, led;
  logic [6:0] nvp; // presets left to copy
  panel_t pnl = '0;
  logic [32:0] rd_q[$]; // {slverr, data} per read
  logic [7:0] tx_q[$]; // expected transmitted bytes
  logic [32:0] r;
  logic [7:0] t;
  int err_count = 0;
  int comparisons = 0;
  int tx_count = 0;
  preset_t pa, pb;
  always #5 clk = ~clk;
  // short copy and blink times keep the run brief
  preset_manager #(.NV_STEP(10), .FLASH(4)) u_preset_manager (
    .CORE_CLK(clk), .RST(rst), .CE(1'b1), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .MENU_BTN(pnl.menu),
    .BANK_BTN(pnl.bank), .NUMBER_BTN(pnl.number), .FOOT_BTN(pnl.foot),
    .RX_VALID(rx_valid), .RX_DATA(rx_data), .TX_VALID(tx_valid),
    .TX_DATA(tx_data), .TX_READY(tx_ready), .LED(led),
    .STORE_PROMPT(prompt), .TRAFFIC_MUTE(mute), .PLAY_BLOCK(block),
    .NV_PROGRESS(nvp));
  midi_host u_midi_host (.clk(clk), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_ready(tx_ready));
  // watchers take the oldest note whenever a result appears
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite && rd_q.size() > 0) begin
      r = rd_q.pop_front();
      `CHK({pslverr, prdata}, r)
    end
    if (tx_valid && tx_ready) begin
      tx_count++;
      `CHK(mute, 1'b1)
      if (tx_q.size() > 0) begin
        t = tx_q.pop_front();
        `CHK(tx_data, t)
      end
    end
  end
  task automatic test_done;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // apb transfer: setup, then access held until pready
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) begin
      err_count++;
      test_done();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic work(input preset_t p);
    for (int i = 0; i < 8; i++) begin
      rd(ADDR_WORK + 12'(4 * i), {25'h0, p[i]});
    end
  endtask
  // hold a button pattern past the synchroniser, then release
  task automatic press(input logic [7:0] m, input logic [7:0] b,
    input logic [7:0] n, input logic f);
    @(posedge clk);
    pnl <= '{m, b, n, f};
    tick(4);
    pnl <= '0;
    tick(6);
  endtask
  function automatic logic [7:0] sum7(input preset_t d);
    logic [6:0] s;
    s = 7'h00;
    for (int i = 0; i < 8; i++) s += d[i][6:0];
    return {1'b0, s};
  endfunction
  task automatic msg(input logic [7:0] c, input logic [7:0] i);
    u_midi_host.send(SX_START);
    u_midi_host.send(SX_ID);
    u_midi_host.send(c);
    u_midi_host.send(i);
  endtask
  // preset record; bad flips the low checksum bit
  task automatic rec(input logic [7:0] c, input logic [6:0] i,
    input preset_t d, input logic bad);
    msg(c, {1'b0, i});
    for (int k = 0; k < 8; k++) u_midi_host.send(d[k]);
    u_midi_host.send(sum7(d) ^ {7'h0, bad});
    u_midi_host.send(SX_END);
  endtask
  task automatic pc(input logic [7:0] s, input logic [7:0] p);
    u_midi_host.send(s);
    u_midi_host.send(p);
    tick(3);
  endtask
  task automatic wait_tx;
    int k;
    k = 0;
    tick(4);
    while ((tx_valid === 1'b1 || tx_q.size() > 0) && k < 30000) begin
      tick(1);
      k++;
    end
    if (k == 30000) begin
      err_count++;
      test_done();
    end
  endtask
  task automatic blink_err;
    tick(4);
    for (int i = 0; i < 12; i++) begin
      `CHK(led == LED_ERR || led == LED_OFF, 1'b1)
      tick(1);
    end
  endtask
  initial begin
    void'($urandom(32'h093a));
    for (int i = 0; i < 8; i++) begin
      pa[i] = 8'($urandom % 128);
      pb[i] = 8'($urandom % 128);
    end
    pa[0] = 8'h09; // preset 5 points at preset 9
    tick(16);
    rst <= 1'b0;
    tick(2);
    `CHK(led, MENU_FIRST)
    rd(ADDR_STATUS, 33'h0);
    rd(12'h100, {1'b1, 32'h0});
    rec(CMD_REC_ONE, 7'h05, pa, 1'b0);
    rec(CMD_REC_ONE, 7'h09, pb, 1'b0);
    press(8'h00, 8'h02, 8'h00, 1'b0);
    press(8'h00, 8'h00, 8'h02, 1'b0);
    work(pb);
    pc(8'hc0, 8'h05);
    work(pa);
    pc(8'hc1, 8'h09);
    work(pa);
    apb(1'b1, ADDR_CTRL, 32'h12);
    pc(8'hc2, 8'h09);
    work(pb);
    press(8'h01, 8'h00, 8'h00, 1'b0);
    rd(ADDR_STATUS, 33'h18);
    press(8'h81, 8'h00, 8'h00, 1'b0);
    `CHK({prompt, led}, {1'b1, LED_ALL})
    press(8'h00, 8'h04, 8'h00, 1'b0);
    press(8'h00, 8'h00, 8'h08, 1'b0);
    `CHK(prompt, 1'b0)
    // notes go in first: the reply starts while the request ends
    tx_q = {SX_START, SX_ID, CMD_REC_ONE, 8'h53};
    for (int i = 0; i < 8; i++) tx_q.push_back(pb[i]);
    tx_q.push_back(sum7(pb));
    tx_q.push_back(SX_END);
    msg(CMD_REQ_ONE, 8'h53);
    u_midi_host.send(SX_END);
    wait_tx();
    press(8'h81, 8'h00, 8'h00, 1'b0);
    press(8'h04, 8'h00, 8'h00, 1'b0);
    `CHK({prompt, led}, {1'b0, MENU_FIRST})
    rec(CMD_REC_ONE, 7'h05, pb, 1'b1);
    blink_err();
    press(8'h01, 8'h00, 8'h00, 1'b0);
    pc(8'hc2, 8'h05);
    work(pa);
    rec(CMD_REC_OLD, 7'h3f, pb, 1'b0);
    blink_err();
    press(8'h01, 8'h00, 8'h00, 1'b0);
    pc(8'hc2, 8'h3f);
    work(pb);
    pc(8'hc2, 8'h05);
    press(8'h00, 8'h00, 8'h00, 1'b1);
    work(pb);
    apb(1'b1, ADDR_WORK, 32'h21);
    rd(ADDR_CUR, {1'b0, 32'h2109});
    apb(1'b1, ADDR_CTRL, 32'h02);
    pc(8'hc2, 8'h05);
    rd(ADDR_CUR, {1'b0, 32'h2109});
    tx_count = 0;
    tx_q.push_back(SX_START);
    msg(CMD_REQ_ALL, SX_END);
    wait_tx();
    `CHK(tx_count, 1792)
    tx_count = 0;
    press(8'h40, 8'h00, 8'h00, 1'b0);
    press(8'h00, 8'h08, 8'h00, 1'b0);
    wait_tx();
    `CHK(tx_count, 1792)
    msg(CMD_STORE, 8'h05);
    tick(2);
    `CHK(block, 1'b1)
    tick(12);
    u_midi_host.send(SX_END);
    `CHK({block, nvp}, 8'h00)
    rec(CMD_REC_FULL, 7'h7f, pa, 1'b0);
    tick(3);
    `CHK({block, mute}, 2'b11)
    `CHK(nvp, LAST_PRESET)
    tick(1300);
    `CHK(block, 1'b0)
    `CHK(nvp, 7'h0)
    test_done();
  end
endmodule
`default_nettype wire

// file: verilog/preset_manager.sv
// preset recall, store and system-exclusive dump engine
// Summary of operation
// - 128 presets by bank, number, range
// - preset menu press toggles range half
// - number press recalls bank/range/number preset
// - recall overwrites work memory; store only
// - preset menu active after reset
// - master-channel program change recalls, others ignored
// - first+last menu arms store, all LEDs
// - armed: bank, range, number writes location
// - other menu press cancels store, no write
// - menu seven bank four sends all
// - full request sends whole memory
// - single request sends one preset
// - dump traffic mutes other MIDI traffic
// - full dump triggers blocking non-volatile copy
// - single dump updates volatile only
// - checksum error aborts, flashes alternate LEDs
// - checksum checked per preset record
// - older dumps: 64 presets, then error
// - footswitch recalls preset pointer target
// - program number maps directly to preset
`timescale 1ns/1ns
`default_nettype none
module preset_manager
  import preset_pkg::*;
#(
  parameter int unsigned NV_STEP = NV_STEP_DEFAULT, // cycles per preset
  parameter int unsigned FLASH = FLASH_DEFAULT // blink half period
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [7:0] MENU_BTN,
  input wire logic [7:0] BANK_BTN,
  input wire logic [7:0] NUMBER_BTN,
  input wire logic FOOT_BTN,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  output logic TX_VALID,
  output logic [7:0] TX_DATA,
  input wire logic TX_READY,
  output logic [7:0] LED,
  output logic STORE_PROMPT,
  output logic TRAFFIC_MUTE,
  output logic PLAY_BLOCK,
  output logic [6:0] NV_PROGRESS
);
  // lowest set bit of a one-hot button group
  function automatic logic [2:0] enc8(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction
  // record checksum: byte sum modulo 128
  function automatic logic [6:0] csum(input preset_t p);
    logic [6:0] s;
    s = 7'h0;
    for (int i = 0; i < PRESET_BYTES; i++) begin
      s = s + p[i][6:0];
    end
    return s;
  endfunction

  preset_t preset_mem [NUM_PRESETS]; // volatile preset store
  preset_t work; // working memory, the only editable copy
  preset_t rx_buf; // staged record until its checksum passes
  panel_t s1, s2, s3; // button synchroniser and edge history
  panel_t rise; // one-cycle press events
  ctrl_t ctrl; // master channel and program-change recall enable
  rx_state_t rx_state;
  logic [2:0] menu, bank; // selected menu and bank
  logic range; // upper half when set
  logic armed; // store mode armed
  logic err; // checksum or legacy dump error
  logic [6:0] cur; // index of last recalled preset
  logic [7:0] rx_cmd; // command of the sysex in progress
  logic [6:0] rx_idx; // preset addressed by that sysex
  logic [2:0] rx_cnt; // data byte position
  logic tx_on, tx_all; // dump transmitter busy, whole memory
  logic [6:0] tx_idx;
  logic [3:0] tx_pos;
  logic nv_busy; // non-volatile copy running
  logic [6:0] nv_left; // presets still to copy
  logic [31:0] nv_cnt, flash_cnt;
  logic flash; // blink phase
  logic frozen; // panel and input blocked
  logic arm_go, recall_go, store_go, dump_go;
  logic [6:0] sel_idx, recall_idx;
  logic rx_byte, rx_sx, pc_go, commit, bad_sum, old_end;
  logic req_all, req_one, store_msg, full_end, tx_hs;

  // pins pass two flops; only s2 and s3 are read by logic
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else if (CE) begin
      s1 <= '{MENU_BTN, BANK_BTN, NUMBER_BTN, FOOT_BTN};
      s2 <= s1;
      s3 <= s2;
    end
  end
  assign rise = s2 & ~s3;

  // panel decisions
  assign frozen = nv_busy | err;
  assign sel_idx = {range, bank, enc8(rise.number)};
  assign arm_go = !frozen && s2.menu[0] && s2.menu[7] &&
                  (rise.menu[0] || rise.menu[7]);
  assign store_go = !frozen && armed && !arm_go &&
                    rise.menu == '0 && rise.number != '0;
  assign dump_go = !frozen && !armed && menu == MENU_PARAMS &&
                   rise.bank[DUMP_BANK];
  assign pc_go = rx_byte && rx_state == RX_PC && !RX_DATA[7];
  always_comb begin
    recall_go = 1'b0;
    recall_idx = sel_idx;
    if (pc_go) begin
      recall_go = 1'b1;
      recall_idx = RX_DATA[6:0];
    end else if (!frozen && !armed && !arm_go && rise.foot) begin
      recall_go = 1'b1;
      recall_idx = work[0][6:0];
    end else if (!frozen && !armed && !arm_go &&
                 menu == MENU_PRESET && rise.number != '0) begin
      recall_go = 1'b1;
    end
  end

  // menu, range, bank and store mode
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      menu <= MENU_PRESET;
      range <= 1'b0;
      bank <= 3'h0;
      armed <= 1'b0;
    end else if (CE && !frozen) begin
      if (arm_go) begin
        armed <= 1'b1;
        menu <= MENU_PRESET;
      end else if (armed && rise.menu == MENU_FIRST) begin
        range <= ~range;
      end else if (armed && rise.menu != '0) begin
        armed <= 1'b0;
      end else if (rise.menu != '0) begin
        menu <= enc8(rise.menu);
        // a preset-menu press inside the preset menu flips the half
        if (rise.menu[0] && menu == MENU_PRESET) begin
          range <= ~range;
        end
      end else if (store_go) begin
        armed <= 1'b0;
      end
      if (rise.bank != '0 && (armed || menu == MENU_PRESET)) begin
        bank <= enc8(rise.bank);
      end
    end
  end

  // working memory: recall copy or register edit
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      work <= '0;
      cur <= 7'h0;
    end else if (CE) begin
      if (recall_go) begin
        work <= preset_mem[recall_idx];
        cur <= recall_idx;
      end else if (PSEL && PENABLE && PWRITE &&
                   PADDR >= ADDR_WORK && PADDR <= ADDR_WORK_LAST) begin
        work[PADDR[4:2]] <= PWDATA[7:0];
      end
    end
  end

  // preset store: written only by store or a good record
  always_ff @(posedge CORE_CLK) begin
    if (CE) begin
      if (store_go) begin
        preset_mem[sel_idx] <= work;
      end else if (commit) begin
        preset_mem[rx_idx] <= rx_buf;
      end
    end
  end

  // incoming MIDI parser, ignored while copying or in error
  assign rx_byte = CE && RX_VALID && !frozen && RX_DATA < RT_FIRST;
  assign rx_sx = rx_state != RX_IDLE && rx_state != RX_PC;
  assign bad_sum = rx_byte && rx_state == RX_SUM &&
                   RX_DATA[6:0] != csum(rx_buf);
  assign commit = rx_byte && rx_state == RX_SUM && !bad_sum &&
                  !(rx_cmd == CMD_REC_OLD && rx_idx > OLD_LAST);
  assign old_end = commit && rx_cmd == CMD_REC_OLD && rx_idx == OLD_LAST;
  assign full_end = commit && rx_cmd == CMD_REC_FULL &&
                    rx_idx == LAST_PRESET;
  assign req_all = rx_byte && rx_state == RX_CMD && RX_DATA == CMD_REQ_ALL;
  assign req_one = rx_byte && rx_state == RX_ARG && rx_cmd == CMD_REQ_ONE;
  assign store_msg = rx_byte && rx_state == RX_ARG && rx_cmd == CMD_STORE;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rx_state <= RX_IDLE;
      rx_cmd <= 8'h0;
      rx_idx <= 7'h0;
      rx_cnt <= 3'h0;
      rx_buf <= '0;
    end else if (CE && err) begin
      rx_state <= RX_IDLE;
    end else if (CE && dump_go && !tx_on && rx_state == RX_PC) begin
      rx_state <= RX_IDLE;
    end else if (rx_byte) begin
      if (RX_DATA == SX_START) begin
        rx_state <= RX_ID;
      end else if (RX_DATA[7]) begin
        // program change only on the master channel when enabled
        if (RX_DATA[7:4] == PC_STATUS && RX_DATA[3:0] == ctrl.chan &&
            ctrl.pc_en && !rx_sx && !tx_on) begin
          rx_state <= RX_PC;
        end else begin
          rx_state <= RX_IDLE;
        end
      end else begin
        unique case (rx_state)
          RX_IDLE, RX_PC: rx_state <= RX_IDLE;
          RX_ID: rx_state <= RX_DATA == SX_ID ? RX_CMD : RX_SKIP;
          RX_CMD: begin
            rx_cmd <= RX_DATA;
            rx_state <= RX_DATA == CMD_REQ_ALL ? RX_SKIP : RX_ARG;
          end
          RX_ARG: begin
            rx_idx <= RX_DATA[6:0];
            rx_cnt <= 3'h0;
            if (rx_cmd == CMD_REC_FULL || rx_cmd == CMD_REC_ONE ||
                rx_cmd == CMD_REC_OLD) begin
              rx_state <= RX_BODY;
            end else begin
              rx_state <= RX_SKIP;
            end
          end
          RX_BODY: begin
            rx_buf[rx_cnt] <= RX_DATA;
            rx_cnt <= rx_cnt + 3'h1;
            if (rx_cnt == 3'h7) begin
              rx_state <= RX_SUM;
            end
          end
          RX_SUM: rx_state <= RX_SKIP;
          RX_SKIP: rx_state <= RX_SKIP;
        endcase
      end
    end
  end

  // error latch; a new fault in the clearing cycle wins
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      err <= 1'b0;
    end else if (CE) begin
      if (bad_sum || old_end) begin
        err <= 1'b1;
      end else if (rise.menu != '0) begin
        err <= 1'b0;
      end
    end
  end

  // blink timer for the error pattern
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      flash_cnt <= 32'h0;
      flash <= 1'b0;
    end else if (CE) begin
      if (!err || flash_cnt == FLASH - 1) begin
        flash_cnt <= 32'h0;
        flash <= err & ~flash;
      end else begin
        flash_cnt <= flash_cnt + 32'h1;
      end
    end
  end

  // non-volatile copy: whole memory after full dump, one on store
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      nv_busy <= 1'b0;
      nv_left <= 7'h0;
      nv_cnt <= 32'h0;
    end else if (CE) begin
      if (!nv_busy && (full_end || store_msg)) begin
        nv_busy <= 1'b1;
        nv_left <= full_end ? LAST_PRESET : 7'h0;
        nv_cnt <= 32'h0;
      end else if (nv_busy && nv_cnt == NV_STEP - 1) begin
        nv_cnt <= 32'h0;
        // stop at zero so progress reads empty once the copy is done
        if (nv_left == 7'h0) begin
          nv_busy <= 1'b0;
        end else begin
          nv_left <= nv_left - 7'h1;
        end
      end else if (nv_busy) begin
        nv_cnt <= nv_cnt + 32'h1;
      end
    end
  end

  // dump transmitter, 14 bytes per record
  assign tx_hs = tx_on && TX_READY;
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      tx_on <= 1'b0;
      tx_all <= 1'b0;
      tx_idx <= 7'h0;
      tx_pos <= 4'h0;
      TX_DATA <= 8'h0;
    end else if (CE) begin
      if (!tx_on && (dump_go || req_all || req_one)) begin
        tx_on <= 1'b1;
        tx_all <= !req_one;
        tx_idx <= req_one ? RX_DATA[6:0] : 7'h0;
        tx_pos <= 4'h0;
        TX_DATA <= SX_START;
      end else if (tx_hs) begin
        tx_pos <= tx_pos + 4'h1;
        unique case (tx_pos + 4'h1)
          4'h1: TX_DATA <= SX_ID;
          4'h2: TX_DATA <= tx_all ? CMD_REC_FULL : CMD_REC_ONE;
          4'h3: TX_DATA <= {1'b0, tx_idx};
          4'hc: TX_DATA <= {1'b0, csum(preset_mem[tx_idx])};
          4'hd: TX_DATA <= SX_END;
          4'he: TX_DATA <= SX_START;
          default: TX_DATA <= preset_mem[tx_idx][3'(tx_pos - 4'h3)];
        endcase
        if (tx_pos == TX_LAST_POS) begin
          tx_pos <= 4'h0;
          tx_idx <= tx_idx + 7'h1;
          if (!tx_all || tx_idx == LAST_PRESET) begin
            tx_on <= 1'b0;
          end
        end
      end
    end
  end
  assign TX_VALID = tx_on;

  // indicator drive
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      LED <= MENU_FIRST;
    end else if (CE) begin
      if (err) begin
        LED <= flash ? LED_OFF : LED_ERR;
      end else if (armed) begin
        LED <= LED_ALL;
      end else begin
        LED <= 8'(1) << menu;
      end
    end
  end
  assign STORE_PROMPT = armed;
  assign TRAFFIC_MUTE = tx_on | rx_sx | nv_busy;
  assign PLAY_BLOCK = nv_busy;
  assign NV_PROGRESS = nv_left;

  // APB slave: no wait states, read data latched in setup
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctrl <= CTRL_RESET;
    end else if (CE && PSEL && PENABLE && PWRITE && PADDR == ADDR_CTRL) begin
      ctrl <= '{pad: 27'h0, pc_en: PWDATA[4], chan: PWDATA[3:0]};
    end
  end
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      PRDATA <= 32'h0;
      PSLVERR <= 1'b0;
    end else if (CE && PSEL && !PENABLE) begin
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0;
      if (PADDR == ADDR_CTRL) begin
        PRDATA <= ctrl;
      end else if (PADDR == ADDR_STATUS) begin
        PRDATA <= status_t'{pad: 20'h0, rx_on: rx_sx, tx_on: tx_on,
                  nv_busy: nv_busy, err: err, armed: armed, bank: bank,
                  range: range, menu: menu};
      end else if (PADDR == ADDR_CUR) begin
        PRDATA <= {9'h0, nv_left, 1'b0, work[0][6:0], 1'b0, cur};
      end else if (PADDR >= ADDR_WORK && PADDR <= ADDR_WORK_LAST &&
                   PADDR[1:0] == 2'h0) begin
        PRDATA <= {24'h0, work[PADDR[4:2]]};
      end else begin
        PSLVERR <= 1'b1; // unmapped
      end
    end
  end
  assign PREADY = 1'b1;

  // checks
  chk_reset_menu: assert property (@(posedge CORE_CLK)
    $fell(RST) |-> menu == MENU_PRESET && !armed)
    else $error("menu not preset after reset");
  chk_range_toggle: assert property (@(posedge CORE_CLK)
    disable iff (RST || !CE)
    !frozen && !armed && menu == MENU_PRESET && rise.menu == MENU_FIRST
    |=> range != $past(range))
    else $error("preset press did not toggle range");
  chk_recall_copy: assert property (@(posedge CORE_CLK)
    disable iff (RST || !CE)
    recall_go && !store_go |=> work == $past(preset_mem[recall_idx]))
    else $error("recall did not load work memory");
  chk_store_leds: assert property (@(posedge CORE_CLK)
    disable iff (RST || !CE)
    armed && $past(armed) && !err |-> LED == LED_ALL && STORE_PROMPT)
    else $error("armed store without full indicators");
  chk_store_write: assert property (@(posedge CORE_CLK)
    disable iff (RST || !CE)
    store_go |=> preset_mem[$past(sel_idx)] == $past(work) && !armed)
    else $error("store did not write location");
  chk_store_cancel: assert property (@(posedge CORE_CLK)
    disable iff (RST || !CE)
    armed && !frozen && !arm_go && rise.menu != '0 &&
    rise.menu != MENU_FIRST |=> !armed ##1 LED != LED_ALL)
    else $error("store mode not cancelled");
  chk_dump_mute: assert property (@(posedge CORE_CLK)
    disable iff (RST)
    (tx_on || rx_sx) |-> TRAFFIC_MUTE && rx_state != RX_PC)
    else $error("traffic not muted during dump");
  chk_pc_channel: assert property (@(posedge CORE_CLK)
    disable iff (RST || !CE)
    rx_byte && RX_DATA[7:4] == PC_STATUS && RX_DATA[3:0] != ctrl.chan
    |=> rx_state != RX_PC)
    else $error("foreign channel program change accepted");
  chk_sum_abort: assert property (@(posedge CORE_CLK)
    disable iff (RST || !CE)
    bad_sum |=> err && rx_state == RX_SKIP ##1 rx_state == RX_IDLE)
    else $error("checksum error not aborting");
  chk_old_limit: assert property (@(posedge CORE_CLK)
    disable iff (RST || !CE)
    old_end |=> err)
    else $error("older dump overrun not flagged");
  cov_store: cover property (@(posedge CORE_CLK) arm_go ##[1:50] store_go);
  cov_full_tx: cover property (@(posedge CORE_CLK) $fell(tx_on) && tx_all);
  cov_nv_copy: cover property (@(posedge CORE_CLK) $fell(nv_busy));
endmodule
`default_nettype wire

// file: verilog/preset_pkg.sv
// constants, types and the register map of the preset manager
package preset_pkg;
  localparam int unsigned NUM_PRESETS = 128; // stored preset locations
  localparam int unsigned RANGE_SIZE = 64; // presets per range half
  localparam int unsigned PRESET_BYTES = 8; // bytes in one preset record
  localparam int unsigned CLK_KHZ = 100000; // core clock rate
  localparam int unsigned NV_COPY_MS = 120000; // full non-volatile copy
  localparam int unsigned NV_STEP_DEFAULT =
    int'(64'(NV_COPY_MS) * 64'(CLK_KHZ) / 64'(NUM_PRESETS));
  localparam int unsigned FLASH_MS = 250; // error blink half period
  localparam int unsigned FLASH_DEFAULT = FLASH_MS * CLK_KHZ;
  // register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_CUR = 12'h008;
  localparam logic [11:0] ADDR_WORK = 12'h020; // 8 words up to 0x03c
  localparam logic [11:0] ADDR_WORK_LAST = 12'h03c;
  // system-exclusive framing and commands
  localparam logic [7:0] SX_START = 8'hf0;
  localparam logic [7:0] SX_END = 8'hf7;
  localparam logic [7:0] SX_ID = 8'h7d; // arbitrary identity value
  localparam logic [7:0] CMD_REQ_ALL = 8'h01;
  localparam logic [7:0] CMD_REQ_ONE = 8'h02;
  localparam logic [7:0] CMD_REC_FULL = 8'h10;
  localparam logic [7:0] CMD_REC_ONE = 8'h11;
  localparam logic [7:0] CMD_STORE = 8'h12;
  localparam logic [7:0] CMD_REC_OLD = 8'h13;
  localparam logic [3:0] PC_STATUS = 4'hc; // program change nibble
  localparam logic [7:0] RT_FIRST = 8'hf8; // realtime bytes and above
  localparam logic [3:0] TX_LAST_POS = 4'hd; // 14 bytes per record
  localparam logic [3:0] TX_DATA_POS = 4'h4; // first data byte slot
  localparam logic [6:0] LAST_PRESET = 7'h7f;
  localparam logic [6:0] OLD_LAST = 7'h3f; // last preset of older dumps
  // panel
  localparam logic [2:0] MENU_PRESET = 3'h0;
  localparam logic [2:0] MENU_PARAMS = 3'h6;
  localparam logic [2:0] DUMP_BANK = 3'h3;
  localparam logic [7:0] MENU_FIRST = 8'h01;
  localparam logic [7:0] LED_ALL = 8'hff;
  localparam logic [7:0] LED_ERR = 8'h55;
  localparam logic [7:0] LED_OFF = 8'h00;
  typedef logic [7:0][7:0] preset_t; // byte 0 is next_preset_pointer
  typedef struct packed {
    logic [7:0] menu;
    logic [7:0] bank;
    logic [7:0] number;
    logic foot;
  } panel_t;
  typedef struct packed {
    logic [26:0] pad;
    logic pc_en;
    logic [3:0] chan;
  } ctrl_t;
  localparam ctrl_t CTRL_RESET = '{pad: 27'h0, pc_en: 1'b1, chan: 4'h0};
  typedef struct packed {
    logic [19:0] pad;
    logic rx_on;
    logic tx_on;
    logic nv_busy;
    logic err;
    logic armed;
    logic [2:0] bank;
    logic range;
    logic [2:0] menu;
  } status_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_PC = 3'b001,
    RX_ID = 3'b010,
    RX_CMD = 3'b011,
    RX_ARG = 3'b100,
    RX_BODY = 3'b101,
    RX_SUM = 3'b110,
    RX_SKIP = 3'b111
  } rx_state_t;
endpackage
